//--- design/jdcr_pkg.sv
package jdcr_pkg;
	// register indices of the receive control block (word addresses)
	localparam logic [2:0] REG_LEN      = 3'h0;
	localparam logic [2:0] REG_RSVD1    = 3'h1;
	localparam logic [2:0] REG_STATUS   = 3'h2;
	localparam logic [2:0] REG_FLAGS    = 3'h3;
	localparam logic [2:0] REG_RSVD4    = 3'h4;
	localparam logic [2:0] REG_PEER_ADR = 3'h5;
	localparam logic [2:0] REG_MAX_LEN  = 3'h6;
	localparam logic [2:0] REG_TIMEOUT  = 3'h7;

	// result status codes
	localparam logic [15:0] ST_NORMAL   = 16'h0000;
	localparam logic [15:0] ST_TIMEOUT  = 16'h000a;
	localparam logic [15:0] ST_TOO_LONG = 16'h0064;
	localparam logic [15:0] ST_OVER_252 = 16'h0065;
	localparam logic [15:0] ST_MP_FAIL  = 16'h0066;

	// limits and field positions
	localparam logic [7:0]  ADDR_MAX     = 8'hfe;
	localparam logic [15:0] LEN_LIMIT    = 16'h00fc;
	localparam logic [15:0] SEG_BYTES    = 16'h0008;
	localparam int          FLAG_OVW_BIT = 0;
	localparam logic [17:0] REQ_PGN      = 18'h0ea00;

	// reset values
	localparam logic [7:0]  PEER_ADR_RST = 8'h00;
	localparam logic [15:0] MAX_LEN_RST  = 16'h00fc;
	localparam logic [15:0] TIMEOUT_RST  = 16'h0000;

	// timeout step is 10 ms at 25 MHz
	localparam int          STEP_MS      = 10;
	localparam int          CLK_KHZ      = 25000;
	localparam int          STEP_CYCLES  = STEP_MS * CLK_KHZ;

	// one received segment from the CAN receive logic
	typedef struct packed {
		logic        valid;
		logic [7:0]  src_addr;
		logic        first;
		logic        last;
		logic        abort;
		logic [15:0] total_len;
		logic [63:0] data;
	} jdcr_seg_t;

	// request message handed to the transmit side
	typedef struct packed {
		logic        valid;
		logic [7:0]  dest_addr;
		logic [17:0] pgn;
	} jdcr_req_t;
endpackage

//--- design/jdcr_receive.sv
// Summary of operation
// - peer address register accepts 0 to 254 and selects the peer's segments
// - 64-bit peer name held; all-zero means name undefined
// - received byte length goes to word zero of the control block
// - messages over 8 bytes arrive as 8-byte segments
// - segments reassembled; payload copied to storage only after final one
// - over maximum length stores maximum as length and status 100 below 252 bytes
// - status word cleared only by software writing zero
// - overwrite flag bit 0 high for exactly one scan
// - status 10 when receive-cycle interval passes without a message
// - status 101 when message length is 252 bytes or more
// - status 102 when a multi-packet message is not fully received
// - request trigger sends request PGN 59904 at next scan end
// - receive alert pulses for one scan after a message arrives
// - messages buffered internally, copied to storage at scan end
// - repeats within one scan keep only the latest content
// - timeout in 10 ms steps, zero disables monitoring
// - maximum length setting limited to 252 bytes
`timescale 1ns/100ps
module jdcr_receive
(
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst,
	// scan end strobe and request trigger
	input  wire logic               scan_end,
	input  wire logic               request_trigger,
	// segments from the can receiver
	input  wire jdcr_pkg::jdcr_seg_t seg_in,
	// peer name configuration
	input  wire logic [63:0]        peer_name,
	output logic                    peer_name_defined,
	// register port
	input  wire logic [2:0]         reg_addr,
	input  wire logic [15:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [15:0]             reg_rdata,
	// storage port and status outputs
	output logic [7:0]              store_wr_addr,
	output logic [7:0]              store_wr_data,
	output logic                    store_wr_en,
	output jdcr_pkg::jdcr_req_t     req_out,
	output logic                    receive_alert_pulse
);
	localparam int BUF_W = 256;

	// configuration registers
	logic [7:0]  peer_adr_reg, peer_adr_next;
	logic [15:0] max_len_reg, max_len_next;
	logic [15:0] timeout_reg, timeout_next;
	// control block
	logic [15:0] len_reg, len_next;
	logic [15:0] status_reg, status_next;
	logic        ovw_reg, ovw_next;
	logic        alert_reg, alert_next;
	logic        lost_reg, lost_next;
	logic        name_def_reg, name_def_next;
	// assembly and pending buffers
	logic [7:0]  asm_mem [BUF_W];
	logic [7:0]  pend_mem [BUF_W];
	logic [15:0] asm_len_reg, asm_len_next;
	logic [7:0]  asm_ptr_reg, asm_ptr_next;
	logic        asm_busy_reg, asm_busy_next;
	logic        pend_reg, pend_next;
	logic [15:0] pend_len_reg, pend_len_next;
	logic        copy_reg, copy_next;
	logic [7:0]  cp_cnt_reg, cp_cnt_next;
	logic [7:0]  cp_len_reg, cp_len_next;
	// timeout and request
	logic [17:0] tick_reg, tick_next;
	logic [15:0] step_reg, step_next;
	logic        req_arm_reg, req_arm_next;
	jdcr_pkg::jdcr_req_t req_reg, req_next;
	logic [7:0]  sw_adr_reg, sw_adr_next;
	logic        sw_we_reg, sw_we_next;
	logic [7:0]  sw_dat_reg, sw_dat_next;
	logic [15:0] rdata_reg, rdata_next;

	logic        from_peer;
	logic        msg_done;
	logic        mp_fail;
	logic        lost_ev;
	logic [15:0] ev_code;
	logic        ev_set;

	// clamp a configured length to the 252-byte ceiling
	function automatic logic [15:0] clamp_len(input logic [15:0] v);
		clamp_len = (v > jdcr_pkg::LEN_LIMIT) ? jdcr_pkg::LEN_LIMIT : v;
	endfunction

	// ======================================================================
	// segment intake
	assign from_peer = seg_in.valid
		&& (seg_in.src_addr == peer_adr_reg);
	assign msg_done  = from_peer && seg_in.last && !seg_in.abort;
	// an abort, or a new first segment that cuts a busy transfer, fails it when its length is over 8 bytes
	assign mp_fail   = from_peer && ((seg_in.abort
		&& seg_in.total_len > jdcr_pkg::SEG_BYTES)
		|| (seg_in.first && asm_busy_reg
		&& asm_len_reg > jdcr_pkg::SEG_BYTES));
	assign name_def_next = (peer_name != 64'h0);

	// byte writes into assembly memory, one segment per cycle
	always_ff @(posedge sys_clk)
	begin
		if (from_peer && !seg_in.abort)
		begin
			for (int i = 0; i < 8; i++)
			begin
				asm_mem[8'(asm_ptr_next - 8'h08 + 8'(i))] <=
					seg_in.data[8*i +: 8];
			end
		end
		if (msg_done)
		begin
			pend_mem <= asm_mem;
			for (int i = 0; i < 8; i++)
			begin
				pend_mem[8'(asm_ptr_next - 8'h08 + 8'(i))] <=
					seg_in.data[8*i +: 8];
			end
		end
	end

	// ======================================================================
	// assembly pointer and pending state
	always_comb
	begin
		asm_ptr_next  = asm_ptr_reg;
		asm_len_next  = asm_len_reg;
		asm_busy_next = asm_busy_reg;
		pend_next     = pend_reg;
		pend_len_next = pend_len_reg;
		lost_ev       = 1'b0;
		if (from_peer)
		begin
			if (seg_in.first)
			begin
				asm_ptr_next = 8'h08;
				asm_len_next = seg_in.total_len;
			end
			else
			begin
				asm_ptr_next = 8'(asm_ptr_reg + 8'h08);
			end
			asm_busy_next = !(seg_in.last || seg_in.abort);
			if (seg_in.abort)
			begin
				asm_busy_next = 1'b0;
			end
		end
		if (scan_end)
		begin
			pend_next = 1'b0;
		end
		if (msg_done)
		begin
			lost_ev       = pend_reg && !scan_end;
			pend_next     = 1'b1;
			pend_len_next = seg_in.first ? seg_in.total_len : asm_len_reg;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			asm_ptr_reg  <= 8'h00;
			asm_len_reg  <= 16'h0000;
			asm_busy_reg <= 1'b0;
			pend_reg     <= 1'b0;
			pend_len_reg <= 16'h0000;
		end
		else
		begin
			asm_ptr_reg  <= asm_ptr_next;
			asm_len_reg  <= asm_len_next;
			asm_busy_reg <= asm_busy_next;
			pend_reg     <= pend_next;
			pend_len_reg <= pend_len_next;
		end
	end

	// ======================================================================
	// cycle timeout: counts 10 ms steps, zero setting disables
	always_comb
	begin
		tick_next = tick_reg;
		step_next = step_reg;
		if (msg_done || timeout_reg == 16'h0000)
		begin
			tick_next = 18'h0;
			step_next = 16'h0;
		end
		else if (step_reg != timeout_reg)
		begin
			if (tick_reg == 18'(jdcr_pkg::STEP_CYCLES - 1))
			begin
				tick_next = 18'h0;
				step_next = 16'(step_reg + 16'h1);
			end
			else
			begin
				tick_next = 18'(tick_reg + 18'h1);
			end
		end
	end

	// ======================================================================
	// scan-end commit of the control block, copy launch and flags
	always_comb
	begin
		ev_set  = 1'b0;
		ev_code = jdcr_pkg::ST_NORMAL;
		if (mp_fail)
		begin
			ev_set  = 1'b1;
			ev_code = jdcr_pkg::ST_MP_FAIL;
		end
		else if (timeout_reg != 16'h0 && step_reg != timeout_reg
			&& step_next == timeout_reg)
		begin
			ev_set  = 1'b1;
			ev_code = jdcr_pkg::ST_TIMEOUT;
		end
	end

	always_comb
	begin
		len_next     = len_reg;
		status_next  = status_reg;
		ovw_next     = ovw_reg;
		alert_next   = alert_reg;
		copy_next    = copy_reg;
		cp_cnt_next  = cp_cnt_reg;
		cp_len_next  = cp_len_reg;
		req_arm_next = req_arm_reg || request_trigger;
		req_next     = '0;
		if (reg_wr && reg_addr == jdcr_pkg::REG_STATUS
			&& reg_wdata == 16'h0000)
		begin
			status_next = jdcr_pkg::ST_NORMAL;
		end
		if (ev_set)
		begin
			status_next = ev_code; // set wins over clear
		end
		// a loss is remembered and shown only from the next scan end
		lost_next = lost_reg || lost_ev;
		if (scan_end)
		begin
			lost_next  = 1'b0;
			ovw_next   = lost_reg;
			alert_next = pend_reg;
			if (pend_reg)
			begin
				copy_next   = 1'b1;
				cp_cnt_next = 8'h00;
				if (pend_len_reg >= jdcr_pkg::LEN_LIMIT)
				begin
					status_next = jdcr_pkg::ST_OVER_252;
				end
				if (pend_len_reg > max_len_reg)
				begin
					len_next    = max_len_reg;
					cp_len_next = max_len_reg[7:0];
					if (pend_len_reg < jdcr_pkg::LEN_LIMIT)
					begin
						status_next = jdcr_pkg::ST_TOO_LONG;
					end
				end
				else
				begin
					len_next    = pend_len_reg;
					cp_len_next = pend_len_reg[7:0];
				end
			end
			if (req_arm_reg || request_trigger)
			begin
				req_next.valid     = 1'b1;
				req_next.dest_addr = peer_adr_reg;
				req_next.pgn       = jdcr_pkg::REQ_PGN;
				req_arm_next       = 1'b0;
			end
		end
		else if (copy_reg)
		begin
			cp_cnt_next = 8'(cp_cnt_reg + 8'h1);
			copy_next   = (8'(cp_cnt_reg + 8'h1) != cp_len_reg);
		end
		if (copy_next && cp_len_next == 8'h00)
		begin
			copy_next = 1'b0;
		end
	end

	// storage write port, one byte per cycle after commit
	assign sw_we_next  = copy_reg && !scan_end;
	assign sw_adr_next = cp_cnt_reg;
	assign sw_dat_next = pend_mem[cp_cnt_reg];

	// ======================================================================
	// register write and read decode
	always_comb
	begin
		peer_adr_next = peer_adr_reg;
		max_len_next  = max_len_reg;
		timeout_next  = timeout_reg;
		if (reg_wr && reg_addr == jdcr_pkg::REG_PEER_ADR
			&& reg_wdata[7:0] <= jdcr_pkg::ADDR_MAX)
		begin
			peer_adr_next = reg_wdata[7:0];
		end
		if (reg_wr && reg_addr == jdcr_pkg::REG_MAX_LEN)
		begin
			max_len_next = clamp_len(reg_wdata);
		end
		if (reg_wr && reg_addr == jdcr_pkg::REG_TIMEOUT)
		begin
			timeout_next = reg_wdata;
		end
		rdata_next = 16'h0000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				jdcr_pkg::REG_LEN:      rdata_next = len_reg;
				jdcr_pkg::REG_STATUS:   rdata_next = status_reg;
				jdcr_pkg::REG_FLAGS:    rdata_next = 16'(ovw_reg);
				jdcr_pkg::REG_PEER_ADR: rdata_next = {8'h00, peer_adr_reg};
				jdcr_pkg::REG_MAX_LEN:  rdata_next = max_len_reg;
				jdcr_pkg::REG_TIMEOUT:  rdata_next = timeout_reg;
				default:                rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			peer_adr_reg <= jdcr_pkg::PEER_ADR_RST;
			max_len_reg  <= jdcr_pkg::MAX_LEN_RST;
			timeout_reg  <= jdcr_pkg::TIMEOUT_RST;
			len_reg      <= 16'h0000;
			status_reg   <= jdcr_pkg::ST_NORMAL;
			ovw_reg      <= 1'b0;
			lost_reg     <= 1'b0;
			name_def_reg <= 1'b0;
			alert_reg    <= 1'b0;
			copy_reg     <= 1'b0;
			cp_cnt_reg   <= 8'h00;
			cp_len_reg   <= 8'h00;
			tick_reg     <= 18'h0;
			step_reg     <= 16'h0;
			req_arm_reg  <= 1'b0;
			req_reg      <= '0;
			sw_adr_reg   <= 8'h00;
			sw_we_reg    <= 1'b0;
			sw_dat_reg   <= 8'h00;
			rdata_reg    <= 16'h0000;
		end
		else
		begin
			peer_adr_reg <= peer_adr_next;
			max_len_reg  <= max_len_next;
			timeout_reg  <= timeout_next;
			len_reg      <= len_next;
			status_reg   <= status_next;
			ovw_reg      <= ovw_next;
			lost_reg     <= lost_next;
			name_def_reg <= name_def_next;
			alert_reg    <= alert_next;
			copy_reg     <= copy_next;
			cp_cnt_reg   <= cp_cnt_next;
			cp_len_reg   <= cp_len_next;
			tick_reg     <= tick_next;
			step_reg     <= step_next;
			req_arm_reg  <= req_arm_next;
			req_reg      <= req_next;
			sw_adr_reg   <= sw_adr_next;
			sw_we_reg    <= sw_we_next;
			sw_dat_reg   <= sw_dat_next;
			rdata_reg    <= rdata_next;
		end
	end

	assign reg_rdata           = rdata_reg;
	assign receive_alert_pulse = alert_reg;
	assign peer_name_defined   = name_def_reg;
	assign req_out             = req_reg;
	assign store_wr_addr       = sw_adr_reg;
	assign store_wr_data       = sw_dat_reg;
	assign store_wr_en         = sw_we_reg;

	// ======================================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	alert_scan_a: assert property (scan_end ##1 1 |->
		receive_alert_pulse == $past(pend_reg))
		else $error("alert not one scan");
	alert_hold_a: assert property (!scan_end |=>
		$stable(receive_alert_pulse))
		else $error("alert changed mid scan");
	req_send_a: assert property (scan_end && request_trigger |=>
		req_out.valid && req_out.pgn == jdcr_pkg::REQ_PGN)
		else $error("request not sent");
	req_only_a: assert property (req_out.valid |-> $past(scan_end))
		else $error("request off scan end");
	max_len_a: assert property (max_len_reg <= jdcr_pkg::LEN_LIMIT)
		else $error("max length above 252");
	peer_adr_a: assert property (peer_adr_reg <= jdcr_pkg::ADDR_MAX)
		else $error("peer address out of range");
	len_clip_a: assert property (scan_end && pend_reg
		&& pend_len_reg > max_len_reg |=> len_reg == $past(max_len_reg))
		else $error("length not clipped");
	stat_keep_a: assert property (!reg_wr && !ev_set && !scan_end
		|=> $stable(status_reg)) else $error("status lost");
	mp_fail_a: assert property (mp_fail
		|=> status_reg == jdcr_pkg::ST_MP_FAIL)
		else $error("multi-packet error missed");
	ovw_scan_a: assert property (scan_end && lost_reg |=> ovw_reg)
		else $error("overwrite flag missed");
	ovw_hold_a: assert property (!scan_end |=> $stable(ovw_reg))
		else $error("overwrite flag changed mid scan");

	rx_msg_c: cover property (msg_done ##[1:20] scan_end);
	ovw_c: cover property (lost_ev);
	timeout_c: cover property (ev_code == jdcr_pkg::ST_TIMEOUT);
	req_c: cover property (req_out.valid);
endmodule

//--- tb/jdcr_peer.sv
`timescale 1ns/100ps
module jdcr_peer
(
	// clock
	input  wire logic           sys_clk,
	// segment stream toward the receiver
	output jdcr_pkg::jdcr_seg_t seg
);
	// ==========================================================
	// peer application sending one message
	// ==========================================================
	initial seg = '0;

	// splits a message into 8-byte segments; an abort replaces segment two
	// idle data is inverted so a stale payload never looks fresh
	task automatic send(input logic [7:0] src, input logic [15:0] len,
		input logic ab, input logic [7:0] base);
		jdcr_pkg::jdcr_seg_t s;
		int                  n;
		n = ab ? 2 : (int'(len) + 7) / 8;
		for (int k = 0; k < n; k++)
		begin
			s.valid     = 1'b1;
			s.src_addr  = src;
			s.first     = (k == 0);
			s.last      = !ab && (k == n - 1);
			s.abort     = ab && (k == 1);
			s.total_len = len;
			for (int b = 0; b < 8; b++)
				s.data[8*b +: 8] = base + 8'(8 * k + b);
			@(posedge sys_clk);
			seg <= s;
		end
		@(posedge sys_clk);
		s.valid = 1'b0;
		s.data  = ~s.data;
		seg <= s;
	endtask
endmodule

//--- tb/jdcr_receive_test.sv
`timescale 1ns/100ps
module jdcr_receive_test;
	// ==========================================================
	// clock, stimulus and design
	// ==========================================================
	logic                sys_clk, rst, scan_end, request_trigger;
	logic                reg_wr, reg_rd, peer_name_defined;
	logic                store_wr_en, receive_alert_pulse, s_alert;
	logic [63:0]         peer_name;
	logic [2:0]          reg_addr;
	logic [15:0]         reg_wdata, reg_rdata;
	logic [7:0]          store_wr_addr, store_wr_data;
	logic [7:0]          mem [256];
	jdcr_pkg::jdcr_seg_t seg_in;
	jdcr_pkg::jdcr_req_t req_out, s_req;
	int                  bad_count, comparisons, wcnt;

	jdcr_receive jdcr_receive_i (.sys_clk(sys_clk), .rst(rst),
		.scan_end(scan_end), .request_trigger(request_trigger),
		.seg_in(seg_in), .peer_name(peer_name),
		.peer_name_defined(peer_name_defined), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .store_wr_addr(store_wr_addr),
		.store_wr_data(store_wr_data), .store_wr_en(store_wr_en),
		.req_out(req_out), .receive_alert_pulse(receive_alert_pulse));
	jdcr_peer jdcr_peer_i (.sys_clk(sys_clk), .seg(seg_in));

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// storage image built from the byte copy port
	always @(posedge sys_clk)
		if (store_wr_en === 1'b1)
		begin
			mem[store_wr_addr] = store_wr_data;
			wcnt++;
		end

	// ==========================================================
	// access tasks
	// ==========================================================
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			bad_count++;
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdc(input logic [2:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask

	// one-cycle scan end; results sampled once the commit edge has landed
	task automatic scan();
		@(posedge sys_clk);
		scan_end <= 1'b1;
		@(posedge sys_clk);
		scan_end <= 1'b0;
		#1 s_alert = receive_alert_pulse;
		s_req = req_out;
	endtask

	// commit one message and compare length, status and storage copy
	task automatic commit(input int n, input logic [7:0] b,
		input logic [15:0] st);
		chk(16'(wcnt), 16'h0000);
		scan();
		chk({15'h0, s_alert}, 16'h0001);
		chk({15'h0, s_req.valid}, 16'h0000);
		rdc(jdcr_pkg::REG_LEN, 16'(n));
		rdc(jdcr_pkg::REG_STATUS, st);
		repeat (n + 12) @(posedge sys_clk);
		chk(16'(wcnt), 16'(n));
		for (int i = 0; i < n; i++)
			chk({8'h0, mem[i]}, {8'h0, b + 8'(i)});
		wcnt = 0;
	endtask

	task automatic complete_run();
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// a run of well under a thousand cycles; 20000 is ample margin
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		complete_run();
	end

	// ==========================================================
	// tests
	// ==========================================================
	initial
	begin
		{rst, scan_end, request_trigger, reg_wr, reg_rd} = 5'h10;
		{reg_addr, reg_wdata, peer_name} = '0;
		bad_count = 0;
		comparisons = 0;
		wcnt = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		rdc(jdcr_pkg::REG_MAX_LEN, 16'h00fc);
		rdc(jdcr_pkg::REG_TIMEOUT, 16'h0000);
		rdc(jdcr_pkg::REG_RSVD1, 16'h0000);
		rdc(jdcr_pkg::REG_STATUS, 16'h0000);
		#1 chk({15'h0, peer_name_defined}, 16'h0000);
		peer_name <= 64'h8000_0000_0000_0000;
		@(posedge sys_clk);
		#1 chk({15'h0, peer_name_defined}, 16'h0001);
		wr(jdcr_pkg::REG_PEER_ADR, 16'h00fe);
		wr(jdcr_pkg::REG_PEER_ADR, 16'h00ff);
		rdc(jdcr_pkg::REG_PEER_ADR, 16'h00fe);
		$display("test config done");
		jdcr_peer_i.send(8'h11, 16'h0005, 1'b0, 8'h00);
		scan();
		chk({15'h0, s_alert}, 16'h0000);
		jdcr_peer_i.send(8'hfe, 16'h0005, 1'b0, 8'h20);
		commit(5, 8'h20, jdcr_pkg::ST_NORMAL);
		scan();
		chk({15'h0, s_alert}, 16'h0000);
		jdcr_peer_i.send(8'hfe, 16'h0014, 1'b0, 8'h40);
		commit(20, 8'h40, jdcr_pkg::ST_NORMAL);
		$display("test single and multi-packet done");
		jdcr_peer_i.send(8'hfe, 16'h0005, 1'b0, 8'h10);
		jdcr_peer_i.send(8'hfe, 16'h0006, 1'b0, 8'h60);
		commit(6, 8'h60, jdcr_pkg::ST_NORMAL);
		rdc(jdcr_pkg::REG_FLAGS, 16'h0001);
		scan();
		rdc(jdcr_pkg::REG_FLAGS, 16'h0000);
		$display("test overwrite done");
		wr(jdcr_pkg::REG_MAX_LEN, 16'h0010);
		jdcr_peer_i.send(8'hfe, 16'h0014, 1'b0, 8'h80);
		commit(16, 8'h80, jdcr_pkg::ST_TOO_LONG);
		wr(jdcr_pkg::REG_STATUS, 16'h0005);
		rdc(jdcr_pkg::REG_STATUS, jdcr_pkg::ST_TOO_LONG);
		wr(jdcr_pkg::REG_STATUS, 16'h0000);
		rdc(jdcr_pkg::REG_STATUS, 16'h0000);
		wr(jdcr_pkg::REG_MAX_LEN, 16'h0100);
		rdc(jdcr_pkg::REG_MAX_LEN, 16'h00fc);
		jdcr_peer_i.send(8'hfe, 16'h00fc, 1'b0, 8'h00);
		scan();
		repeat (280) @(posedge sys_clk);
		rdc(jdcr_pkg::REG_STATUS, jdcr_pkg::ST_OVER_252);
		rdc(jdcr_pkg::REG_LEN, 16'h00fc);
		wr(jdcr_pkg::REG_STATUS, 16'h0000);
		jdcr_peer_i.send(8'hfe, 16'h0014, 1'b1, 8'h00);
		scan();
		rdc(jdcr_pkg::REG_STATUS, jdcr_pkg::ST_MP_FAIL);
		$display("test length errors done");
		@(posedge sys_clk);
		request_trigger <= 1'b1;
		@(posedge sys_clk);
		request_trigger <= 1'b0;
		scan();
		chk({15'h0, s_req.valid}, 16'h0001);
		chk(16'(s_req.pgn), 16'hea00);
		chk({8'h0, s_req.dest_addr}, 16'h00fe);
		@(posedge sys_clk);
		#1 chk({15'h0, req_out.valid}, 16'h0000);
		$display("test request done");
		complete_run();
	end
endmodule
